// [hdl/query_response_trigger_scheduler.sv]
// Notes on behaviour
// - cyclic mode issues the query once every update period
// - change mode polls the data area each period, issues only on difference
// - single shot mode issues exactly one query after start, never again
// - trigger mode issues whenever the trigger byte differs from last seen value
// - update time counts in 10 ms units
// - new response data increments response trigger byte when enabled
// - response trigger address only 0x000-0x1ff or 0x400 up to buffer top
// - query trigger address only 0x200-0x3ff or 0x400 up to buffer top
`include "qrts_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module query_response_trigger_scheduler
    import qrts_pkg::*;
#(
    parameter int          ADDR_W     = 12,
    parameter logic [11:0] BUF_TOP    = 12'h7ff,
    parameter int          AREA_MAX   = 16,
    parameter int          UNIT_TICKS = `UNIT_CYCLES
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // memory buffer port, read data one cycle after mem_en
    output logic                   mem_en,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [7:0]             mem_wdata,
    input  wire logic [7:0]        mem_rdata,
    // subnetwork side
    output logic                   query_valid,
    input  wire logic              query_ready,
    input  wire logic              resp_new,
    // interrupt
    output logic                   irq
);
    localparam int LEN_W = $clog2(AREA_MAX + 1);
    localparam int IDX_W = $clog2(AREA_MAX);

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // accepted address windows for the two trigger bytes
    function automatic logic shared_ok(input logic [31:0] a);
        return (a >= 32'(`SHARED_LO)) && (a <= 32'(BUF_TOP));
    endfunction : shared_ok

    function automatic logic qaddr_ok(input logic [31:0] a);
        return ((a >= 32'(`QTRIG_LO)) && (a <= 32'(`QTRIG_HI))) || shared_ok(a);
    endfunction : qaddr_ok

    function automatic logic raddr_ok(input logic [31:0] a);
        return (a <= 32'(`RTRIG_HI)) || shared_ok(a);
    endfunction : raddr_ok

    // register file
    logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [15:0]        upd_reg, upd_next;
    logic [ADDR_W-1:0]  qaddr_reg, qaddr_next, raddr_reg, raddr_next;
    logic [ADDR_W-1:0]  abase_reg, abase_next;
    logic [LEN_W-1:0]   alen_reg, alen_next;
    logic [`ST_W-1:0]   status_reg, status_next, ien_reg, ien_next, st_set, st_clr;
    logic [15:0]        qcount_reg, qcount_next;
    // bus state
    logic               aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0]         waddr_reg, waddr_next;
    logic [31:0]        wdat_reg, wdat_next, rdata_reg, rdata_next, cand;
    logic [3:0]         wstb_reg, wstb_next;
    logic               bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]         bresp_reg, bresp_next, rresp_reg, rresp_next;
    // scheduler state
    sched_state_type    state_reg, state_next;
    mem_op_type         op_reg, op_next;
    logic               mem_en_reg, mem_en_next, mem_we_reg, mem_we_next;
    logic [ADDR_W-1:0]  mem_addr_reg, mem_addr_next;
    logic [7:0]         mem_wdata_reg, mem_wdata_next;
    logic [15:0]        tcnt_reg, tcnt_next;
    logic               qv_reg, qv_next, shot_reg, shot_next, resp_pend_reg, resp_pend_next;
    logic               scan_req_reg, scan_req_next, primed_reg, primed_next;
    logic               diff_reg, diff_next, seen_reg, seen_next;
    logic [7:0]         tlast_reg, tlast_next;
    logic [IDX_W-1:0]   idx_reg, idx_next;
    logic [7:0]         shadow [AREA_MAX];
    logic               shadow_we, issue, tick, period_evt, run, resp_en, scan_last, differs;
    logic               cfg_err;
    logic [15:0]        upd_eff;
    update_mode_type    mode;

    assign run     = ctrl_reg[`CTRL_RUN_BIT];
    assign resp_en = ctrl_reg[`CTRL_RESP_EN_BIT];
    assign mode    = update_mode_type'(ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    assign upd_eff = (upd_reg == 16'h0000) ? 16'h0001 : upd_reg;   // zero acts as one unit

    // 10 ms unit tick
    tick_divider #(.DIV(UNIT_TICKS)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (run),
        .tick    (tick)
    );

    // bus handshakes
    assign awready = !aw_hold_reg;
    assign wready  = !w_hold_reg;
    assign arready = !rvalid_reg;

    // axi4-lite write, read and register updates
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        waddr_next   = waddr_reg;
        wdat_next    = wdat_reg;
        wstb_next    = wstb_reg;
        bvalid_next  = bvalid_reg && !bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        ctrl_next    = ctrl_reg;
        upd_next     = upd_reg;
        qaddr_next   = qaddr_reg;
        raddr_next   = raddr_reg;
        abase_next   = abase_reg;
        alen_next    = alen_reg;
        ien_next     = ien_reg;
        st_clr       = '0;
        cfg_err      = 1'b0;
        cand         = '0;
        if (awvalid && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            waddr_next   = awaddr;
        end
        if (wvalid && !w_hold_reg) begin
            w_hold_next = 1'b1;
            wdat_next   = wdata;
            wstb_next   = wstrb;
        end
        if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `RESP_OKAY;
            unique case (waddr_reg)
                `OFF_CTRL:       ctrl_next = `CTRL_W'(merge(32'(ctrl_reg), wdat_reg, wstb_reg));
                `OFF_UPD_TIME:   upd_next  = 16'(merge(32'(upd_reg), wdat_reg, wstb_reg));
                `OFF_QTRIG_ADDR: begin
                    cand = merge(32'(qaddr_reg), wdat_reg, wstb_reg);
                    if (qaddr_ok(cand)) qaddr_next = ADDR_W'(cand);
                    else begin
                        bresp_next = `RESP_SLVERR;
                        cfg_err    = 1'b1;
                    end
                end
                `OFF_RTRIG_ADDR: begin
                    cand = merge(32'(raddr_reg), wdat_reg, wstb_reg);
                    if (raddr_ok(cand)) raddr_next = ADDR_W'(cand);
                    else begin
                        bresp_next = `RESP_SLVERR;
                        cfg_err    = 1'b1;
                    end
                end
                `OFF_AREA_BASE:  abase_next = ADDR_W'(merge(32'(abase_reg), wdat_reg, wstb_reg));
                `OFF_AREA_LEN: begin
                    cand = merge(32'(alen_reg), wdat_reg, wstb_reg);
                    if (cand <= 32'(AREA_MAX)) alen_next = LEN_W'(cand);
                    else bresp_next = `RESP_SLVERR;
                end
                `OFF_STATUS, `OFF_QUERY_COUNT: bresp_next = `RESP_OKAY;
                `OFF_IRQ_CLEAR:  st_clr   = `ST_W'(merge(32'h0, wdat_reg, wstb_reg));
                `OFF_IRQ_ENABLE: ien_next = `ST_W'(merge(32'(ien_reg), wdat_reg, wstb_reg));
                default:         bresp_next = `RESP_DECERR;
            endcase
        end
        if (arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = `RESP_OKAY;
            unique case (araddr)
                `OFF_CTRL:        rdata_next = 32'(ctrl_reg);
                `OFF_UPD_TIME:    rdata_next = 32'(upd_reg);
                `OFF_QTRIG_ADDR:  rdata_next = 32'(qaddr_reg);
                `OFF_RTRIG_ADDR:  rdata_next = 32'(raddr_reg);
                `OFF_AREA_BASE:   rdata_next = 32'(abase_reg);
                `OFF_AREA_LEN:    rdata_next = 32'(alen_reg);
                `OFF_STATUS:      rdata_next = 32'(status_reg);
                `OFF_IRQ_CLEAR:   rdata_next = 32'h0;
                `OFF_IRQ_ENABLE:  rdata_next = 32'(ien_reg);
                `OFF_QUERY_COUNT: rdata_next = 32'(qcount_reg);
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = `RESP_DECERR;
                end
            endcase
        end
    end

    // scheduler: period timing, query issue and trigger byte access
    always_comb begin
        state_next     = state_reg;
        op_next        = op_reg;
        mem_en_next    = 1'b0;
        mem_we_next    = 1'b0;
        mem_addr_next  = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        shot_next      = shot_reg;
        primed_next    = primed_reg;
        diff_next      = diff_reg;
        seen_next      = seen_reg;
        tlast_next     = tlast_reg;
        idx_next       = idx_reg;
        shadow_we      = 1'b0;
        issue          = 1'b0;
        scan_last      = (32'(idx_reg) + 1) >= 32'(alen_reg);
        differs        = primed_reg && (mem_rdata != shadow[idx_reg]);
        period_evt     = run && tick && (tcnt_reg >= upd_eff - 16'h0001);
        tcnt_next      = !run ? 16'h0000 : (period_evt ? 16'h0000 :
                         (tick ? tcnt_reg + 16'h0001 : tcnt_reg));
        scan_req_next  = scan_req_reg || (period_evt && mode == MODE_CHANGE);
        resp_pend_next = resp_pend_reg;
        if (period_evt && mode == MODE_CYCLIC) issue = 1'b1;
        if (run && mode == MODE_SINGLE && !shot_reg) begin
            issue     = 1'b1;
            shot_next = 1'b1;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (resp_pend_reg && resp_en) begin
                    op_next = OP_RESP;
                    mem_addr_next = raddr_reg;
                    mem_en_next = 1'b1;
                    state_next = ST_RD_WAIT;
                end else if (scan_req_reg) begin
                    scan_req_next = 1'b0;
                    if (alen_reg != '0) begin
                        op_next = OP_SCAN;
                        idx_next = '0;
                        diff_next = 1'b0;
                        mem_addr_next = abase_reg;
                        mem_en_next = 1'b1;
                        state_next = ST_RD_WAIT;
                    end
                end else if (run && mode == MODE_TRIGGER) begin
                    op_next = OP_TRIG;
                    mem_addr_next = qaddr_reg;
                    mem_en_next = 1'b1;
                    state_next = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: state_next = ST_RD_DONE;
            ST_RD_DONE: begin
                state_next = ST_IDLE;
                unique case (op_reg)
                    OP_RESP: begin
                        mem_en_next    = 1'b1;
                        mem_we_next    = 1'b1;
                        mem_wdata_next = mem_rdata + 8'h01;
                        state_next     = ST_WR_WAIT;
                    end
                    OP_SCAN: begin
                        shadow_we = 1'b1;
                        if (scan_last) begin
                            primed_next = 1'b1;
                            issue = issue ||
                                    ((diff_reg || differs) && mode == MODE_CHANGE);
                        end else begin
                            diff_next = diff_reg || differs;
                            idx_next = idx_reg + IDX_W'(1);
                            mem_addr_next = ADDR_W'(abase_reg + ADDR_W'(idx_reg) + ADDR_W'(1));
                            mem_en_next = 1'b1;
                            state_next = ST_RD_WAIT;
                        end
                    end
                    default: begin
                        // any difference, a wrap included, fires the query
                        issue = issue || (seen_reg && mode == MODE_TRIGGER &&
                                (mem_rdata != tlast_reg));
                        seen_next = 1'b1;
                        tlast_next = mem_rdata;
                    end
                endcase
            end
            ST_WR_WAIT: state_next = ST_IDLE;
        endcase
        // response pending: drop when disabled or written, a new arrival wins
        if (!resp_en || (state_reg == ST_RD_DONE && op_reg == OP_RESP)) resp_pend_next = 1'b0;
        if (resp_new && resp_en) resp_pend_next = 1'b1;
        qv_next = (qv_reg && !query_ready) || issue;
        qcount_next = qcount_reg + ((qv_reg && query_ready) ? 16'h0001 : 16'h0000);
        st_set                = '0;
        st_set[`ST_CFG_BIT]   = cfg_err;
        st_set[`ST_QUERY_BIT] = qv_reg && query_ready;
        st_set[`ST_RESP_BIT]  = mem_en_reg && mem_we_reg;
        status_next = (status_reg & ~st_clr) | st_set;   // set wins over clear
    end

    // register all state but the shadow copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0; w_hold_reg <= 1'b0; waddr_reg <= 8'h00;
            wdat_reg <= 32'h0; wstb_reg <= 4'h0; bvalid_reg <= 1'b0; bresp_reg <= `RESP_OKAY;
            rvalid_reg <= 1'b0; rdata_reg <= 32'h0; rresp_reg <= `RESP_OKAY;
            ctrl_reg <= `CTRL_RST; upd_reg <= `UPD_RST;
            qaddr_reg <= ADDR_W'(`QTRIG_RST); raddr_reg <= ADDR_W'(`RTRIG_RST);
            abase_reg <= '0; alen_reg <= '0; ien_reg <= '0; status_reg <= '0;
            qcount_reg <= 16'h0000; state_reg <= ST_IDLE; op_reg <= OP_RESP;
            mem_en_reg <= 1'b0; mem_we_reg <= 1'b0; mem_addr_reg <= '0; mem_wdata_reg <= 8'h00;
            tcnt_reg <= 16'h0000; qv_reg <= 1'b0; shot_reg <= 1'b0; resp_pend_reg <= 1'b0;
            scan_req_reg <= 1'b0; primed_reg <= 1'b0; diff_reg <= 1'b0; seen_reg <= 1'b0;
            tlast_reg <= 8'h00; idx_reg <= '0;
        end else begin
            aw_hold_reg <= aw_hold_next; w_hold_reg <= w_hold_next; waddr_reg <= waddr_next;
            wdat_reg <= wdat_next; wstb_reg <= wstb_next; bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next; rvalid_reg <= rvalid_next; rdata_reg <= rdata_next;
            rresp_reg <= rresp_next; ctrl_reg <= ctrl_next; upd_reg <= upd_next;
            qaddr_reg <= qaddr_next; raddr_reg <= raddr_next; abase_reg <= abase_next;
            alen_reg <= alen_next; ien_reg <= ien_next; status_reg <= status_next;
            qcount_reg <= qcount_next; state_reg <= state_next; op_reg <= op_next;
            mem_en_reg <= mem_en_next; mem_we_reg <= mem_we_next; mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next; tcnt_reg <= tcnt_next; qv_reg <= qv_next;
            shot_reg <= shot_next; resp_pend_reg <= resp_pend_next;
            scan_req_reg <= scan_req_next; primed_reg <= primed_next; diff_reg <= diff_next;
            seen_reg <= seen_next; tlast_reg <= tlast_next; idx_reg <= idx_next;
        end
    end

    // data area shadow copy
    always_ff @(posedge aclk) begin
        if (shadow_we) shadow[idx_reg] <= mem_rdata;
    end

    // outputs
    assign bvalid = bvalid_reg; assign bresp = bresp_reg;
    assign rvalid = rvalid_reg; assign rdata = rdata_reg; assign rresp = rresp_reg;
    assign mem_en = mem_en_reg; assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg; assign mem_wdata = mem_wdata_reg;
    assign query_valid = qv_reg;
    assign irq = |(status_reg & ien_reg);

    sequence s_resp_read;
        state_reg == ST_RD_DONE && op_reg == OP_RESP;
    endsequence
    sequence s_resp_start;
        state_reg == ST_IDLE ##1 state_reg == ST_RD_WAIT && op_reg == OP_RESP;
    endsequence

    a_cyclic_issue: assert property (@(posedge aclk) disable iff (!aresetn)
        period_evt && mode == MODE_CYCLIC |=> qv_reg) else $error("cyclic query missing");
    a_change_poll: assert property (@(posedge aclk) disable iff (!aresetn)
        period_evt && mode == MODE_CHANGE |=> scan_req_reg || state_reg != ST_IDLE)
        else $error("change poll missing");
    a_change_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && mode == MODE_CHANGE |-> op_reg == OP_SCAN && scan_last && primed_reg)
        else $error("change query without scan");
    a_single_once: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(shot_reg) && mode == MODE_SINGLE |-> !issue) else $error("second single shot");
    a_trig_fire: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_RD_DONE && op_reg == OP_TRIG && seen_reg && mode == MODE_TRIGGER &&
        mem_rdata != tlast_reg |=> qv_reg) else $error("trigger change missed");
    a_trig_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        issue && mode == MODE_TRIGGER |-> mem_rdata != tlast_reg)
        else $error("trigger query without change");
    a_period_len: assert property (@(posedge aclk) disable iff (!aresetn)
        period_evt |-> tick && tcnt_reg == upd_eff - 16'h0001) else $error("period length");
    a_resp_incr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_resp_read |=> mem_en && mem_we && mem_addr == raddr_reg &&
        mem_wdata == 8'($past(mem_rdata) + 8'h01)) else $error("response increment");
    a_resp_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        s_resp_start |-> $past(resp_en)) else $error("response write while disabled");
    a_raddr_range: assert property (@(posedge aclk) disable iff (!aresetn)
        raddr_ok(32'(raddr_reg))) else $error("response trigger address out of range");
    a_qaddr_range: assert property (@(posedge aclk) disable iff (!aresetn)
        qaddr_ok(32'(qaddr_reg))) else $error("query trigger address out of range");
endmodule : query_response_trigger_scheduler
`default_nettype wire

// [hdl/qrts_defs.svh]
`ifndef QRTS_DEFS_SVH
`define QRTS_DEFS_SVH

// timing
`define CLK_PERIOD_NS    4
`define UNIT_TIME_MS     10
`define NS_PER_MS        1000000
`define UNIT_CYCLES      ((`UNIT_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS)

// register byte offsets
`define OFF_CTRL         8'h00
`define OFF_UPD_TIME     8'h04
`define OFF_QTRIG_ADDR   8'h08
`define OFF_RTRIG_ADDR   8'h0c
`define OFF_AREA_BASE    8'h10
`define OFF_AREA_LEN     8'h14
`define OFF_STATUS       8'h18
`define OFF_IRQ_CLEAR    8'h1c
`define OFF_IRQ_ENABLE   8'h20
`define OFF_QUERY_COUNT  8'h24

// control fields
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    1
`define CTRL_RUN_BIT     2
`define CTRL_RESP_EN_BIT 3
`define CTRL_W           4

// status / interrupt bits
`define ST_QUERY_BIT     0
`define ST_RESP_BIT      1
`define ST_CFG_BIT       2
`define ST_W             3

// trigger byte address windows
`define RTRIG_LO         12'h000
`define RTRIG_HI         12'h1ff
`define QTRIG_LO         12'h200
`define QTRIG_HI         12'h3ff
`define SHARED_LO        12'h400

// reset values
`define CTRL_RST         4'h0
`define UPD_RST          16'h0001
`define QTRIG_RST        12'h200
`define RTRIG_RST        12'h000

// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define RESP_DECERR      2'h3

`endif

// [hdl/qrts_pkg.sv]
package qrts_pkg;
    typedef enum logic [1:0] {
        MODE_CYCLIC,
        MODE_CHANGE,
        MODE_SINGLE,
        MODE_TRIGGER
    } update_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_DONE,
        ST_WR_WAIT
    } sched_state_type;

    typedef enum logic [1:0] {
        OP_RESP,
        OP_SCAN,
        OP_TRIG
    } mem_op_type;
endpackage : qrts_pkg

// [hdl/tick_divider.sv]
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
    parameter int DIV = 2500000
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control and output
    input  wire logic enable,
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    logic          tick_next;

    // count enabled cycles, pulse once per full division
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!enable) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(DIV - 1)) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    // register divider state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule : tick_divider
`default_nettype wire

// [test/buf_model.sv]
`timescale 1ns/1ns
`default_nettype none
module buf_model (
    // clock
    input  wire logic        aclk,
    // memory buffer port
    input  wire logic        mem_en,
    input  wire logic        mem_we,
    input  wire logic [11:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [4096];
    // store bytes; read data only holds in the cycle after the strobe
    always @(posedge aclk) begin
        if (mem_en && mem_we) mem[mem_addr] <= mem_wdata;
        mem_rdata <= (mem_en && !mem_we) ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : buf_model
`default_nettype wire

// [test/query_response_trigger_scheduler_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module query_response_trigger_scheduler_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic        awready, wready, arready, mem_en, mem_we, query_valid, query_ready;
    logic        resp_new, irq;
    logic [7:0]  awaddr, araddr, mem_wdata, mem_rdata;
    logic [31:0] wdata, rdata, v, c;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    logic [11:0] mem_addr;
    int          bad_count, checked, n;
    query_response_trigger_scheduler #(.UNIT_TICKS(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .mem_en(mem_en),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .query_valid(query_valid), .query_ready(query_ready), .resp_new(resp_new), .irq(irq)
    );
    buf_model u_mem (
        .aclk(aclk), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
    );
    // free running clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    // a wait that ran out of its bound ends the run
    task automatic guard(input int k);
        if (k >= 300) begin
            bad_count++;
            close_out();
        end
    endtask : guard
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && k < 300);
        guard(k);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && k < 300);
        guard(k);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // count edges until a query is offered
    task automatic wq();
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!query_valid && n < 300);
        guard(n);
    endtask : wq
    task automatic pulse();
        @(posedge aclk);
        resp_new <= 1'b1;
        @(posedge aclk);
        resp_new <= 1'b0;
    endtask : pulse
    task automatic t_regs();
        rd(8'h04);
        chk(v, 32'h1);
        wr(8'h08, 32'h100);
        chk(r, 2'h2);
        wr(8'h0c, 32'h200);
        chk(r, 2'h2);
        wr(8'h0c, 32'h400);
        chk(r, 2'h0);
        rd(8'h40);
        chk(r, 2'h3);
        $display("done regs");
    endtask : t_regs
    task automatic t_modes();
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h4);
        wq();
        wq();
        chk(n, 8);
        wr(8'h00, 32'h0);
        rd(8'h24);
        c = v;
        wr(8'h00, 32'h6);
        repeat (100) @(posedge aclk);
        rd(8'h24);
        chk(v, c + 1);
        wr(8'h00, 32'h7);
        repeat (40) @(posedge aclk);
        rd(8'h24);
        chk(v, c + 1);
        u_mem.mem[12'h201] = 8'h5a;
        u_mem.mem[12'h200] = 8'h00;
        wq();
        rd(8'h24);
        chk(v, c + 2);
        wr(8'h00, 32'h0);
        $display("done modes");
    endtask : t_modes
    // data area scan: baseline, quiet, then one change held until accepted
    task automatic t_change();
        u_mem.mem[12'h300] = 8'h00;
        u_mem.mem[12'h301] = 8'h00;
        wr(8'h10, 32'h300);
        wr(8'h14, 32'h2);
        rd(8'h24);
        c = v;
        wr(8'h00, 32'h5);
        repeat (60) @(posedge aclk);
        rd(8'h24);
        chk(v, c);
        query_ready <= 1'b0;
        u_mem.mem[12'h301] = 8'h11;
        wq();
        repeat (3) @(posedge aclk);
        chk(query_valid, 1'b1);
        query_ready <= 1'b1;
        rd(8'h24);
        chk(v, c + 1);
        wr(8'h00, 32'h0);
        $display("done change");
    endtask : t_change
    task automatic t_resp();
        wr(8'h0c, 32'h10);
        wr(8'h20, 32'h2);
        wr(8'h00, 32'h8);
        pulse();
        n = 0;
        while (!irq && n < 300) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        chk(u_mem.mem[12'h010], 8'h00);
        wr(8'h1c, 32'h2);
        @(posedge aclk);
        chk(irq, 1'b0);
        wr(8'h00, 32'h0);
        pulse();
        repeat (20) @(posedge aclk);
        chk(u_mem.mem[12'h010], 8'h00);
        $display("done resp");
    endtask : t_resp
    // reset, then the scenarios in turn
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, resp_new} = '0;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
        query_ready = 1'b1;
        u_mem.mem[12'h200] = 8'hff;
        u_mem.mem[12'h010] = 8'hff;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_change();
        t_resp();
        close_out();
    end
endmodule : query_response_trigger_scheduler_tb
`default_nettype wire
